// ==== verilog/vat_decode.sv ====
// virtual area decode, access check and physical address formation
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "vat_consts.svh"
module vat_decode (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rd_data,
  input wire vat_pkg::vat_req_t req,
  output logic req_ready,
  output vat_pkg::vat_tlb_req_t tlb_req,
  input wire vat_pkg::vat_tlb_resp_t tlb_resp,
  output vat_pkg::vat_result_t result
);
  vat_pkg::vat_state_t state;
  vat_pkg::vat_state_t next_state;
  logic translation_enable;
  logic single_space_mode;
  logic storeq_user_lock;
  logic cache_enable;
  logic copy_back_select;
  logic write_through_select;
  logic local_memory_user_allow;
  logic [7:0] space_identifier;
  logic [21:0] virtual_page_number;
  logic [31:0] fault_addr;
  logic [31:0] pend_vaddr;
  logic pend_user;
  logic pend_write;
  logic take;
  logic lookup_done;
  logic [2:0] seg;
  vat_pkg::vat_target_t win;
  vat_pkg::vat_result_t dec;
  logic dec_needs_tlb;
  vat_pkg::vat_result_t xl;
  logic [28:0] size_mask;
  logic [28:0] xl_paddr;
  logic fault_event;
  logic [31:0] fault_vaddr;

  assign take = req_ready && req.valid;
  assign lookup_done = (state == vat_pkg::VAT_ST_WAIT) && tlb_resp.valid;
  assign seg = req.vaddr[31:29];

  // internal resource window decode
  always_comb begin
    win = vat_pkg::VAT_TGT_INT_OTHER;
    if (req.vaddr[31:26] == `VAT_WIN_STOREQ) begin
      win = vat_pkg::VAT_TGT_STOREQ;
    end else if (req.vaddr[31:24] == `VAT_WIN_LMEM) begin
      win = vat_pkg::VAT_TGT_LMEM;
    end else if (req.vaddr[31:24] == `VAT_WIN_IC_TAG) begin
      win = vat_pkg::VAT_TGT_IC_TAG;
    end else if (req.vaddr[31:24] == `VAT_WIN_IC_DATA) begin
      win = vat_pkg::VAT_TGT_IC_DATA;
    end else if (req.vaddr[31:24] == `VAT_WIN_OC_TAG) begin
      win = vat_pkg::VAT_TGT_OC_TAG;
    end else if (req.vaddr[31:24] == `VAT_WIN_OC_DATA) begin
      win = vat_pkg::VAT_TGT_OC_DATA;
    end else if (req.vaddr[31:24] == `VAT_WIN_FBUF_TAG) begin
      win = vat_pkg::VAT_TGT_FBUF_TAG;
    end else if (req.vaddr[31:23] == `VAT_WIN_FBUF_DATA) begin
      win = vat_pkg::VAT_TGT_FBUF_DATA;
    end else if (req.vaddr[31:20] == `VAT_WIN_UBUF_TAG) begin
      win = vat_pkg::VAT_TGT_UBUF_TAG;
    end else if (req.vaddr[31:20] == `VAT_WIN_UBUF_DATA) begin
      win = vat_pkg::VAT_TGT_UBUF_DATA;
    end else if (req.vaddr[31:20] == `VAT_WIN_FMB_TAG) begin
      win = vat_pkg::VAT_TGT_FMB_TAG;
    end else if (req.vaddr[31:20] == `VAT_WIN_FMB_DATA) begin
      win = vat_pkg::VAT_TGT_FMB_DATA;
    end else if (req.vaddr[31:26] == `VAT_WIN_PERIPH) begin
      win = vat_pkg::VAT_TGT_PERIPH;
    end
  end

  // area decode of the incoming request
  always_comb begin
    dec = '0;
    dec.valid = 1'b1;
    dec.paddr = req.vaddr[28:0];
    dec.target = vat_pkg::VAT_TGT_MEM;
    dec_needs_tlb = 1'b0;
    if (req.vaddr[31] == 1'b0 || seg == `VAT_SEG_HIGH) begin
      if (req.user && req.vaddr[31]) begin
        dec.addr_error = 1'b1;
      end else if (translation_enable) begin
        dec_needs_tlb = 1'b1;
      end else begin
        dec.cacheable = cache_enable;
        dec.write_through = write_through_select;
      end
    end else if (seg == `VAT_SEG_CACHED) begin
      dec.addr_error = req.user;
      dec.cacheable = cache_enable && !req.user;
      dec.write_through = !copy_back_select;
    end else if (seg == `VAT_SEG_UNCACHED) begin
      dec.addr_error = req.user;
    end else begin
      dec.target = win;
      dec.paddr = req.vaddr[28:0];
      if (req.user) begin
        if (win == vat_pkg::VAT_TGT_STOREQ) begin
          dec.addr_error = storeq_user_lock;
        end else if (win == vat_pkg::VAT_TGT_LMEM) begin
          dec.addr_error = !local_memory_user_allow;
        end else begin
          dec.addr_error = 1'b1;
        end
      end
    end
    // direct accesses into physical area 7 see only the reserved area
    if (!dec_needs_tlb && seg != `VAT_SEG_INTERNAL &&
        req.vaddr[28:26] == `VAT_PHYS_AREA7) begin
      dec.target = vat_pkg::VAT_TGT_RESERVED;
      dec.cacheable = 1'b0;
    end
    if (dec.addr_error) begin
      dec.cacheable = 1'b0;
      dec.write_through = 1'b0;
      dec_needs_tlb = 1'b0;
    end
  end

  // page offset width from the entry's size code
  always_comb begin
    unique case (tlb_resp.page_size)
      `VAT_PS_1K: size_mask = `VAT_MASK_1K;
      `VAT_PS_4K: size_mask = `VAT_MASK_4K;
      `VAT_PS_64K: size_mask = `VAT_MASK_64K;
      `VAT_PS_1M: size_mask = `VAT_MASK_1M;
    endcase
  end

  assign xl_paddr = ({tlb_resp.ppn, 10'h000} & ~size_mask) | (pend_vaddr[28:0] & size_mask);

  // translated result from the lookup answer
  always_comb begin
    xl = '0;
    xl.valid = 1'b1;
    xl.target = vat_pkg::VAT_TGT_MEM;
    if (!tlb_resp.hit) begin
      xl.tlb_miss = 1'b1;
    end else begin
      xl.paddr = xl_paddr;
      // user needs prot[1], a write needs prot[0]; fetches count as reads
      xl.prot_error = (pend_user && !tlb_resp.prot[1]) ||
                      (pend_write && !tlb_resp.prot[0]);
      if (xl_paddr[28:26] == `VAT_PHYS_AREA7) begin
        xl.target = vat_pkg::VAT_TGT_PERIPH;
      end
      xl.cacheable = cache_enable && tlb_resp.cacheable && !xl.prot_error;
      xl.write_through = tlb_resp.write_through;
    end
  end

  assign fault_event = (take && !dec_needs_tlb && dec.addr_error) ||
                       (lookup_done && (xl.tlb_miss || xl.prot_error));
  assign fault_vaddr = take ? req.vaddr : pend_vaddr;

  always_comb begin
    next_state = state;
    unique case (state)
      vat_pkg::VAT_ST_IDLE: begin
        if (take && dec_needs_tlb) begin
          next_state = vat_pkg::VAT_ST_LOOKUP;
        end
      end
      vat_pkg::VAT_ST_LOOKUP: next_state = vat_pkg::VAT_ST_WAIT;
      vat_pkg::VAT_ST_WAIT: begin
        if (tlb_resp.valid) begin
          next_state = vat_pkg::VAT_ST_IDLE;
        end
      end
      default: next_state = vat_pkg::VAT_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= vat_pkg::VAT_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // one access in flight; the core waits on req_ready during a lookup
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      req_ready <= 1'b1;
    end else if (take && dec_needs_tlb) begin
      req_ready <= 1'b0;
    end else if (lookup_done) begin
      req_ready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pend_vaddr <= 32'h00000000;
      pend_user <= 1'b0;
      pend_write <= 1'b0;
    end else if (take) begin
      pend_vaddr <= req.vaddr;
      pend_user <= req.user;
      pend_write <= req.write && !req.fetch;
    end
  end

  // lookup request, one cycle; compare mode and identifier travel with it
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tlb_req <= '0;
    end else if (take && dec_needs_tlb) begin
      tlb_req.valid <= 1'b1;
      tlb_req.fetch_buf <= req.fetch;
      tlb_req.page_num <= req.vaddr[31:10];
      tlb_req.space_id <= space_identifier;
      tlb_req.single_mode <= single_space_mode;
      tlb_req.user <= req.user;
    end else begin
      tlb_req.valid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      result <= '0;
    end else if (take && !dec_needs_tlb) begin
      result <= dec;
    end else if (lookup_done) begin
      result <= xl;
    end else begin
      result.valid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      {storeq_user_lock, single_space_mode, translation_enable} <= `VAT_XC_RESET;
    end else if (reg_wr && reg_addr == `VAT_REG_XLATE_CTRL) begin
      translation_enable <= reg_wr_data[`VAT_XC_TE_BIT];
      single_space_mode <= reg_wr_data[`VAT_XC_SINGLE_BIT];
      storeq_user_lock <= reg_wr_data[`VAT_XC_SQLOCK_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      {write_through_select, copy_back_select, cache_enable} <= `VAT_CC_RESET;
    end else if (reg_wr && reg_addr == `VAT_REG_CACHE_CTRL) begin
      cache_enable <= reg_wr_data[`VAT_CC_EN_BIT];
      copy_back_select <= reg_wr_data[`VAT_CC_COPYBACK_BIT];
      write_through_select <= reg_wr_data[`VAT_CC_WTHRU_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      local_memory_user_allow <= `VAT_LM_RESET;
    end else if (reg_wr && reg_addr == `VAT_REG_LMEM_CTRL) begin
      local_memory_user_allow <= reg_wr_data[`VAT_LM_ALLOW_BIT];
    end
  end

  // a fault capture wins over a software write in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      space_identifier <= 8'h00;
      virtual_page_number <= 22'h000000;
      fault_addr <= 32'h00000000;
    end else begin
      if (reg_wr && reg_addr == `VAT_REG_PAGE_HIGH) begin
        space_identifier <= reg_wr_data[7:0];
        virtual_page_number <= reg_wr_data[31:10];
      end
      if (reg_wr && reg_addr == `VAT_REG_FAULT_ADDR) begin
        fault_addr <= reg_wr_data;
      end
      if (fault_event) begin
        virtual_page_number <= fault_vaddr[31:10];
        fault_addr <= fault_vaddr;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rd_data <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `VAT_REG_XLATE_CTRL: reg_rd_data <= {29'h0, storeq_user_lock,
                                             single_space_mode, translation_enable};
        `VAT_REG_CACHE_CTRL: reg_rd_data <= {29'h0, write_through_select,
                                             copy_back_select, cache_enable};
        `VAT_REG_LMEM_CTRL: reg_rd_data <= {31'h0, local_memory_user_allow};
        `VAT_REG_PAGE_HIGH: reg_rd_data <= {virtual_page_number, 2'h0, space_identifier};
        `VAT_REG_FAULT_ADDR: reg_rd_data <= fault_addr;
        `VAT_REG_STATUS: reg_rd_data <= {21'h0, state, 1'b0, result.prot_error,
                                         result.tlb_miss, result.addr_error, result.target};
        default: reg_rd_data <= 32'h00000000;
      endcase
    end else begin
      reg_rd_data <= 32'h00000000;
    end
  end
endmodule // vat_decode
`default_nettype wire

// ==== verilog/vat_consts.svh ====
// offsets, fields, reset values and window codes of the virtual area decoder
// Contract
// - privileged mode may access the whole 4-Gbyte virtual space.
// - user mode may access only the 2-Gbyte user area, apart from two windows.
// - user store-queue window access allowed only while storeq_user_lock is 0.
// - user local-memory window access allowed only while local_memory_user_allow is 1.
// - other user-mode accesses outside those areas raise an address error.
// - with translation_enable set, translated areas map through pages of 1K/4K/64K/1M.
// - translation off: top 3 bits zeroed, cache per cache control, write-through select.
// - translation on: cached only if globally enabled and entry cacheable; entry picks policy.
// - cached direct area bypasses TLB, zeroes top 3 bits, policy from copy_back_select.
// - uncached direct area uses neither TLB nor cache; top three bits zeroed.
// - internal resource area is never cached and not translated.
// - E000_0000 to E3FF_FFFF decodes as the store-queue window.
// - E500_0000 to E5FF_FFFF decodes as the local-memory window.
// - decode instruction/operand cache tag and data direct-access windows at F0,F1,F4,F5.
// - decode fetch, unified and fixed-mapping buffer array windows F2,F30-F37,F60,F70,F61,F71.
// - FC00_0000 to FFFF_FFFF decodes as peripheral control-register space.
// - 29-bit physical space in eight areas of 0400_0000; area 7 reserved.
// - a TLB-translated access into physical area 7 reaches peripheral registers.
// - fetches search fetch buffer, data the unified buffer; miss raises an exception.
// - single_space_mode selects single or multiple virtual memory comparison.
// - software sets the 8-bit space_identifier; single mode forbids duplicate page numbers.
// - page_size_field 00=1K, 01=4K, 10=64K, 11=1M.
// - protection_code: priv RO, priv RW, both RO, both RW.
`ifndef VAT_CONSTS_SVH
`define VAT_CONSTS_SVH
`define VAT_REG_XLATE_CTRL 8'h00
`define VAT_REG_CACHE_CTRL 8'h04
`define VAT_REG_LMEM_CTRL 8'h08
`define VAT_REG_PAGE_HIGH 8'h0C
`define VAT_REG_FAULT_ADDR 8'h10
`define VAT_REG_STATUS 8'h14
`define VAT_XC_TE_BIT 0
`define VAT_XC_SINGLE_BIT 1
`define VAT_XC_SQLOCK_BIT 2
`define VAT_CC_EN_BIT 0
`define VAT_CC_COPYBACK_BIT 1
`define VAT_CC_WTHRU_BIT 2
`define VAT_LM_ALLOW_BIT 0
`define VAT_XC_RESET 3'h0
`define VAT_CC_RESET 3'h0
`define VAT_LM_RESET 1'h0
`define VAT_SEG_CACHED 3'h4
`define VAT_SEG_UNCACHED 3'h5
`define VAT_SEG_HIGH 3'h6
`define VAT_SEG_INTERNAL 3'h7
`define VAT_WIN_STOREQ 6'h38
`define VAT_WIN_LMEM 8'hE5
`define VAT_WIN_IC_TAG 8'hF0
`define VAT_WIN_IC_DATA 8'hF1
`define VAT_WIN_FBUF_TAG 8'hF2
`define VAT_WIN_FBUF_DATA 9'h1E6
`define VAT_WIN_OC_TAG 8'hF4
`define VAT_WIN_OC_DATA 8'hF5
`define VAT_WIN_UBUF_TAG 12'hF60
`define VAT_WIN_UBUF_DATA 12'hF70
`define VAT_WIN_FMB_TAG 12'hF61
`define VAT_WIN_FMB_DATA 12'hF71
`define VAT_WIN_PERIPH 6'h3F
`define VAT_PHYS_AREA7 3'h7
`define VAT_PS_1K 2'h0
`define VAT_PS_4K 2'h1
`define VAT_PS_64K 2'h2
`define VAT_PS_1M 2'h3
`define VAT_MASK_1K 29'h000003FF
`define VAT_MASK_4K 29'h00000FFF
`define VAT_MASK_64K 29'h0000FFFF
`define VAT_MASK_1M 29'h000FFFFF
`endif

// ==== verilog/vat_pkg.sv ====
// types shared by the virtual area decoder and its bench
package vat_pkg;
  typedef enum logic [2:0] {
    VAT_ST_IDLE = 3'h1,
    VAT_ST_LOOKUP = 3'h2,
    VAT_ST_WAIT = 3'h4
  } vat_state_t;
  typedef enum logic [3:0] {
    VAT_TGT_MEM = 4'h0,
    VAT_TGT_RESERVED = 4'h1,
    VAT_TGT_STOREQ = 4'h2,
    VAT_TGT_LMEM = 4'h3,
    VAT_TGT_IC_TAG = 4'h4,
    VAT_TGT_IC_DATA = 4'h5,
    VAT_TGT_FBUF_TAG = 4'h6,
    VAT_TGT_FBUF_DATA = 4'h7,
    VAT_TGT_OC_TAG = 4'h8,
    VAT_TGT_OC_DATA = 4'h9,
    VAT_TGT_UBUF_TAG = 4'hA,
    VAT_TGT_UBUF_DATA = 4'hB,
    VAT_TGT_FMB_TAG = 4'hC,
    VAT_TGT_FMB_DATA = 4'hD,
    VAT_TGT_PERIPH = 4'hE,
    VAT_TGT_INT_OTHER = 4'hF
  } vat_target_t;
  typedef struct packed {
    logic valid;
    logic [31:0] vaddr;
    logic fetch;
    logic write;
    logic user;
  } vat_req_t;
  typedef struct packed {
    logic valid;
    logic fetch_buf;
    logic [21:0] page_num;
    logic [7:0] space_id;
    logic single_mode;
    logic user;
  } vat_tlb_req_t;
  typedef struct packed {
    logic valid;
    logic hit;
    logic [18:0] ppn;
    logic [1:0] page_size;
    logic [1:0] prot;
    logic cacheable;
    logic write_through;
  } vat_tlb_resp_t;
  typedef struct packed {
    logic valid;
    logic [28:0] paddr;
    vat_target_t target;
    logic cacheable;
    logic write_through;
    logic addr_error;
    logic tlb_miss;
    logic prot_error;
  } vat_result_t;
endpackage

// ==== verif/vat_tlb_model.sv ====
// behavioural translation buffer answering the decoder's lookups
`timescale 1ns/1ps
`default_nettype none
module vat_tlb_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire vat_pkg::vat_tlb_req_t tlb_req,
  input wire vat_pkg::vat_tlb_resp_t cfg,
  input wire logic [3:0] delay,
  output vat_pkg::vat_tlb_resp_t tlb_resp,
  output vat_pkg::vat_tlb_req_t seen
);
  logic busy;
  logic [3:0] cnt;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      tlb_resp <= '0;
      seen <= '0;
    end else if (tlb_req.valid) begin
      busy <= 1'b1;
      cnt <= delay;
      seen <= tlb_req;
      tlb_resp <= {1'b0, ~tlb_resp[25:0]};
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      tlb_resp <= {1'b0, ~tlb_resp[25:0]};
    end else if (busy) begin
      busy <= 1'b0;
      // one answer per lookup, hit or miss with the stored page data
      tlb_resp <= '{1'b1, cfg.hit, cfg.ppn, cfg.page_size, cfg.prot,
        cfg.cacheable && cfg.ppn[18:16] != 3'h7, cfg.write_through};
    end else begin
      // idle fields toggle so a stale value is never mistaken for an answer
      tlb_resp <= {1'b0, ~tlb_resp[25:0]};
    end
  end
endmodule // vat_tlb_model
`default_nettype wire

// ==== verif/vat_decode_chk.sv ====
// port assertions of the virtual area decoder
`timescale 1ns/1ps
`default_nettype none
`include "vat_consts.svh"
module vat_decode_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rd_data,
  input wire vat_pkg::vat_req_t req,
  input wire logic req_ready,
  input wire vat_pkg::vat_tlb_req_t tlb_req,
  input wire vat_pkg::vat_tlb_resp_t tlb_resp,
  input wire vat_pkg::vat_result_t result
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic te;
  logic [31:0] lva;
  wire logic take = req.valid && req_ready;
  wire logic [2:0] seg = req.vaddr[31:29];
  wire logic trn = !req.vaddr[31] || seg == `VAT_SEG_HIGH;
  wire logic xl = te && trn && !(req.user && req.vaddr[31]);
  // shadow of translation_enable, as only the ports are visible here
  always_ff @(posedge core_clk) begin
    if (!rst_b) te <= 1'b0;
    else if (reg_wr && reg_addr == `VAT_REG_XLATE_CTRL) te <= reg_wr_data[`VAT_XC_TE_BIT];
  end
  always_ff @(posedge core_clk) begin
    if (take) lva <= req.vaddr;
  end
  sequence s_resp;
    tlb_resp.valid && !req_ready && !tlb_req.valid;
  endsequence
  sequence s_miss;
    s_resp ##0 !tlb_resp.hit;
  endsequence
  sequence s_hit4k;
    s_resp ##0 (tlb_resp.hit && tlb_resp.page_size == `VAT_PS_4K && tlb_resp.prot == 2'h3);
  endsequence
  chk_uncached_direct: assert property (
    take && seg == `VAT_SEG_UNCACHED && !req.user |=> result.valid && !result.cacheable
    && !tlb_req.valid && result.paddr == $past(req.vaddr[28:0]))
    else $error("uncached direct access wrong");
  chk_cached_direct: assert property (
    take && seg == `VAT_SEG_CACHED && !req.user |=> result.valid
    && !tlb_req.valid && result.paddr == $past(req.vaddr[28:0]))
    else $error("cached direct access wrong");
  chk_internal_uncached: assert property (
    take && seg == `VAT_SEG_INTERNAL && !req.user |=>
    result.valid && !result.cacheable && !tlb_req.valid)
    else $error("internal area cached or looked up");
  chk_lookup_issue: assert property (
    take && xl |=> tlb_req.valid && !req_ready
    && tlb_req.page_num == $past(req.vaddr[31:10]) && tlb_req.fetch_buf == $past(req.fetch))
    else $error("lookup request wrong");
  chk_xlate_off: assert property (
    take && !te && trn && !req.user |=> result.valid
    && !tlb_req.valid && result.paddr == $past(req.vaddr[28:0]))
    else $error("untranslated address wrong");
  chk_miss_flag: assert property (
    s_miss |=> result.valid && result.tlb_miss && !result.cacheable && req_ready)
    else $error("miss not flagged");
  chk_hit_page: assert property (
    s_hit4k |=> result.valid && !result.tlb_miss
    && result.paddr == {$past(tlb_resp.ppn[18:2]), lva[11:0]})
    else $error("translated address wrong");
  chk_user_high: assert property (
    take && req.user && req.vaddr[31] && req.vaddr[31:26] != `VAT_WIN_STOREQ
    && req.vaddr[31:24] != `VAT_WIN_LMEM |=> result.valid && result.addr_error)
    else $error("user address error missing");
  chk_storeq_window: assert property (
    take && !req.user && req.vaddr[31:26] == `VAT_WIN_STOREQ
    |=> result.target == vat_pkg::VAT_TGT_STOREQ)
    else $error("store queue window wrong");
  chk_periph_win: assert property (
    take && !req.user && req.vaddr[31:26] == `VAT_WIN_PERIPH
    |=> result.target == vat_pkg::VAT_TGT_PERIPH)
    else $error("peripheral window wrong");
endmodule // vat_decode_chk
bind vat_decode vat_decode_chk chk_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
  .req(req), .req_ready(req_ready), .tlb_req(tlb_req), .tlb_resp(tlb_resp), .result(result));
`default_nettype wire

// ==== verif/tb_vat_decode.sv ====
// self-checking bench of the virtual area decoder
`timescale 1ns/1ps
`default_nettype none
`include "vat_consts.svh"
module tb_vat_decode;
  logic core_clk, rst_b, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wr_data, reg_rd_data, d;
  logic req_ready;
  logic [3:0] m_delay;
  vat_pkg::vat_req_t req;
  vat_pkg::vat_tlb_req_t tlb_req, seen;
  vat_pkg::vat_tlb_resp_t tlb_resp, m_cfg;
  vat_pkg::vat_result_t result, res;
  int errors, cmp_count, cyc;
  vat_decode dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .req(req), .req_ready(req_ready), .tlb_req(tlb_req), .tlb_resp(tlb_resp), .result(result));
  vat_tlb_model tlb_u (.core_clk(core_clk), .rst_b(rst_b), .tlb_req(tlb_req), .cfg(m_cfg),
    .delay(m_delay), .tlb_resp(tlb_resp), .seen(seen));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic test_done();
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    // whole run needs well under a thousand cycles
    if (cyc == 5000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input logic c, input string m);
    cmp_count++;
    if (c !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wr_data <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rd_data;
    @(posedge core_clk);
  endtask
  task automatic acc(input logic [31:0] va, input logic f, input logic w, input logic u);
    int n;
    req <= '{1'b1, va, f, w, u};
    @(posedge core_clk);
    req.valid <= 1'b0;
    for (n = 0; n < 40; n++) begin
      #1;
      if (result.valid === 1'b1) break;
      @(posedge core_clk);
    end
    chk(n < 40, "no result");
    res = result;
    @(posedge core_clk);
  endtask
  task automatic t_regs();
    rd(`VAT_REG_XLATE_CTRL);
    chk(d === 32'h0, "control reset value");
    wr(`VAT_REG_LMEM_CTRL, 32'h1);
    rd(`VAT_REG_LMEM_CTRL);
    chk(d === 32'h1, "readback");
    wr(`VAT_REG_LMEM_CTRL, 32'h0);
    rd(8'hFC);
    chk(d === 32'h0, "unmapped read");
  endtask
  task automatic t_direct();
    wr(`VAT_REG_CACHE_CTRL, 32'h3);
    acc(32'h80001234, 1'b0, 1'b1, 1'b0);
    chk(res.paddr === 29'h1234 && res.cacheable && !res.write_through, "cached direct");
    acc(32'hA0001234, 1'b0, 1'b0, 1'b0);
    chk(res.paddr === 29'h1234 && res.cacheable === 1'b0, "uncached direct");
    acc(32'h9C000040, 1'b0, 1'b0, 1'b0);
    chk(res.target === vat_pkg::VAT_TGT_RESERVED, "area 7 direct");
    wr(`VAT_REG_CACHE_CTRL, 32'h5);
    acc(32'hC0000010, 1'b0, 1'b1, 1'b0);
    chk(res.paddr === 29'h10 && res.cacheable && res.write_through, "high area");
    wr(`VAT_REG_CACHE_CTRL, 32'h0);
    acc(32'h00000010, 1'b0, 1'b0, 1'b0);
    chk(res.paddr === 29'h10 && res.cacheable === 1'b0, "low uncached");
  endtask
  task automatic t_windows();
    logic [31:0] va [16] = '{32'hE0000000, 32'hE3FFFFFC, 32'hE5000000, 32'hF0000000,
      32'hF1000000, 32'hF2000000, 32'hF3000000, 32'hF4000000, 32'hF5000000, 32'hF6000000,
      32'hF7000000, 32'hF6100000, 32'hF7100000, 32'hFC000000, 32'hFFFFFFFC, 32'hF3800000};
    vat_pkg::vat_target_t tg [16] = '{vat_pkg::VAT_TGT_STOREQ, vat_pkg::VAT_TGT_STOREQ,
      vat_pkg::VAT_TGT_LMEM, vat_pkg::VAT_TGT_IC_TAG, vat_pkg::VAT_TGT_IC_DATA,
      vat_pkg::VAT_TGT_FBUF_TAG, vat_pkg::VAT_TGT_FBUF_DATA, vat_pkg::VAT_TGT_OC_TAG,
      vat_pkg::VAT_TGT_OC_DATA, vat_pkg::VAT_TGT_UBUF_TAG, vat_pkg::VAT_TGT_UBUF_DATA,
      vat_pkg::VAT_TGT_FMB_TAG, vat_pkg::VAT_TGT_FMB_DATA, vat_pkg::VAT_TGT_PERIPH,
      vat_pkg::VAT_TGT_PERIPH, vat_pkg::VAT_TGT_INT_OTHER};
    wr(`VAT_REG_CACHE_CTRL, 32'h1);
    for (int i = 0; i < 16; i++) begin
      acc(va[i], 1'b0, 1'b0, 1'b0);
      chk(res.target === tg[i], "window target");
      chk(!res.cacheable && !res.addr_error, "window access");
    end
  endtask
  task automatic t_user();
    acc(32'h00001000, 1'b0, 1'b0, 1'b1);
    chk(res.addr_error === 1'b0, "user area");
    acc(32'h80000000, 1'b0, 1'b0, 1'b1);
    chk(res.addr_error === 1'b1, "user high");
    acc(32'hE0000000, 1'b0, 1'b1, 1'b1);
    chk(res.addr_error === 1'b0, "storeq open");
    wr(`VAT_REG_XLATE_CTRL, 32'h4);
    acc(32'hE0000000, 1'b0, 1'b1, 1'b1);
    chk(res.addr_error === 1'b1, "storeq locked");
    wr(`VAT_REG_XLATE_CTRL, 32'h0);
    acc(32'hE5000000, 1'b0, 1'b0, 1'b1);
    chk(res.addr_error === 1'b1, "lmem denied");
    wr(`VAT_REG_LMEM_CTRL, 32'h1);
    acc(32'hE5000000, 1'b0, 1'b0, 1'b1);
    chk(res.addr_error === 1'b0, "lmem allowed");
  endtask
  task automatic t_xlate();
    logic [28:0] mk;
    wr(`VAT_REG_PAGE_HIGH, 32'h12);
    wr(`VAT_REG_XLATE_CTRL, 32'h3);
    m_cfg = '{1'b0, 1'b1, 19'h5A5A5, 2'h0, 2'h3, 1'b1, 1'b1};
    for (int s = 0; s < 4; s++) begin
      m_cfg.page_size = 2'(s);
      m_delay = 4'(2 * s);
      mk = (s == 0) ? 29'h3FF : (s == 1) ? 29'hFFF : (s == 2) ? 29'hFFFF : 29'hFFFFF;
      acc(32'h00ABC123, 1'b0, 1'b1, 1'b0);
      chk(res.paddr === (({m_cfg.ppn, 10'h0} & ~mk) | (29'h00ABC123 & mk)), "page");
      chk(res.cacheable === 1'b1 && res.write_through === 1'b1, "page cache");
      chk(seen.space_id === 8'h12 && seen.single_mode && !seen.fetch_buf, "lookup");
    end
    acc(32'h00ABC123, 1'b1, 1'b0, 1'b0);
    chk(seen.fetch_buf === 1'b1, "fetch buffer");
    m_cfg.hit = 1'b0;
    acc(32'hC0001400, 1'b0, 1'b0, 1'b0);
    chk(res.tlb_miss === 1'b1, "miss");
    rd(`VAT_REG_FAULT_ADDR);
    chk(d === 32'hC0001400, "fault address");
    rd(`VAT_REG_PAGE_HIGH);
    chk(d === 32'hC0001412, "fault page and identifier");
    rd(`VAT_REG_STATUS);
    chk(d === 32'h00000120, "miss status");
    m_cfg.hit = 1'b1;
    m_cfg.ppn = 19'h70000;
    acc(32'h00001000, 1'b0, 1'b0, 1'b0);
    chk(res.target === vat_pkg::VAT_TGT_PERIPH, "area 7 mapped");
    m_cfg.ppn = 19'h00400;
    m_cfg.prot = 2'h2;
    acc(32'h00001000, 1'b0, 1'b1, 1'b1);
    chk(res.prot_error === 1'b1, "user write read-only");
    m_cfg.prot = 2'h0;
    wr(`VAT_REG_XLATE_CTRL, 32'h1);
    acc(32'h00001000, 1'b0, 1'b0, 1'b0);
    chk(res.prot_error === 1'b0 && seen.single_mode === 1'b0, "multi mode");
  endtask
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wr_data = 32'h0;
    req = '0;
    m_cfg = '0;
    m_delay = 4'h0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_direct();
    t_windows();
    t_user();
    t_xlate();
    test_done();
  end
endmodule // tb_vat_decode
`default_nettype wire
